// file: design/cbt_core.sv
// AXI4-Lite register file, low-power handshake and time-quantum prescaler
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps

// Operation
// - With privileged-only bit set, refuse non-supervisor register accesses.
// - Raise low-power acknowledge only once disabled, after bus activity finishes.
// - Low-power acknowledge is read-only; reads 1 when disabled, else 0.
// - Buffers taking part equal last buffer index plus one.
// - Last buffer index resets to 0xF, all sixteen buffers active.
// - Interrupt masks and bus-off recovery bit writable in every mode.
// - Quantum clock is selected source divided by prescaler plus one.
// - Prescaler zero divides by one, 0xFF divides by 256.
// - One quantum clock period is the quantum for all segments.
// - Resync jump limited to jump width field plus one quanta.
// - Phase segment one lasts field plus one quanta.
// - Phase segment two lasts field plus one quanta; software uses 1-7.
// - Bus-off interrupt mask enables bus-off request when one.
// - Source select zero picks oscillator, one picks bus clock.
// - Halt bit freezes module when freeze enabled, like debug breakpoint.
// - Module disable bit requests disabled mode, stopping interface clocks.
module cbt_core
    import cbt_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        osc_clk_en,
    input  wire logic        debug_breakpoint,
    input  wire logic        bus_activity,
    input  wire logic        busoff_event,
    input  wire logic        error_event,
    output logic             quantum_tick,
    output logic [4:0]       active_buffer_count,
    output logic [2:0]       resync_jump_width,
    output logic [3:0]       phase_seg_one,
    output logic [3:0]       phase_seg_two,
    output logic             sample_three,
    output logic             loop_back,
    output logic             busoff_recovery_ctrl,
    output logic             can_clock_enable,
    output logic             freeze_active,
    output logic             busoff_irq,
    output logic             error_irq,
    output logic             irq
);
    logic [31:0] module_configuration;
    logic [31:0] can_bus_control;
    logic [31:0] irq_status;
    logic [31:0] irq_mask;
    cbt_mode_t   mode;
    cbt_mode_t   next_mode;
    logic        low_power_ack;
    logic [7:0]  presc_cnt;
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [2:0]  aw_prot;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb,
                                               input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic [31:0] addr_word(input logic [31:0] a);
        return a & CBT_ADDR_MASK;
    endfunction

    wire logic privileged_access_only = module_configuration[CBT_PRIV_POS];
    wire logic module_disable         = module_configuration[CBT_MOD_DIS_POS];
    wire logic frz_en                 = module_configuration[CBT_FRZ_POS];
    wire logic halt_bit               = module_configuration[CBT_HALT_POS];
    wire logic [3:0] last_buffer_index = module_configuration[CBT_LASTMB_LSB +: 4];
    wire logic [7:0] quantum_prescaler = can_bus_control[CBT_PRESC_LSB +: 8];
    wire logic prescaler_source_sel   = can_bus_control[CBT_CLKSRC_POS];
    wire logic busoff_irq_enable      = can_bus_control[CBT_BOFF_EN_POS];
    wire logic error_irq_enable       = can_bus_control[CBT_ERR_EN_POS];

    wire logic freeze_req = frz_en & (halt_bit | debug_breakpoint) & (mode == CBT_RUN);
    wire logic cfg_open   = (mode == CBT_DISABLED) | freeze_req;

    // Write path: address and data may arrive in either order
    wire logic wr_go    = aw_held & w_held & ~s_axi_bvalid;
    wire logic [31:0] wr_word = addr_word(aw_addr);
    wire logic wr_priv_ok = ~privileged_access_only | aw_prot[0];
    wire logic wr_mcr   = wr_go & wr_priv_ok & (wr_word == CBT_MCR_ADDR);
    wire logic wr_ctrl  = wr_go & wr_priv_ok & (wr_word == CBT_CTRL_ADDR);
    wire logic wr_stat  = wr_go & wr_priv_ok & (wr_word == CBT_IRQ_STATUS_ADDR);
    wire logic wr_mask  = wr_go & wr_priv_ok & (wr_word == CBT_IRQ_MASK_ADDR);
    wire logic wr_hit   = (wr_word == CBT_MCR_ADDR) | (wr_word == CBT_CTRL_ADDR)
                        | (wr_word == CBT_IRQ_STATUS_ADDR) | (wr_word == CBT_IRQ_MASK_ADDR);
    wire logic [1:0] wr_resp = ~wr_hit ? CBT_RESP_DECERR
                             : (wr_priv_ok ? CBT_RESP_OKAY : CBT_RESP_SLVERR);

    // masks and recovery always writable, other fields only when disabled or frozen
    wire logic [31:0] ctrl_wmask = cfg_open ? CBT_CTRL_WMASK : CBT_CTRL_ANYTIME;

    wire logic rd_go    = s_axi_arvalid & ~s_axi_rvalid;
    wire logic [31:0] rd_word = addr_word(s_axi_araddr);
    wire logic rd_priv_ok = ~privileged_access_only | s_axi_arprot[0];
    wire logic [31:0] mcr_view = module_configuration
                               | (32'(low_power_ack) << CBT_LPACK_POS)
                               | (32'(mode != CBT_RUN | freeze_req) << CBT_NOTRDY_POS)
                               | (32'(freeze_req) << CBT_FRZACK_POS);
    wire logic rd_hit = (rd_word == CBT_MCR_ADDR) | (rd_word == CBT_CTRL_ADDR)
                      | (rd_word == CBT_IRQ_STATUS_ADDR) | (rd_word == CBT_IRQ_MASK_ADDR);
    wire logic [31:0] rd_mux = (rd_word == CBT_MCR_ADDR)        ? mcr_view
                             : (rd_word == CBT_CTRL_ADDR)       ? can_bus_control
                             : (rd_word == CBT_IRQ_STATUS_ADDR) ? irq_status
                             : (rd_word == CBT_IRQ_MASK_ADDR)   ? irq_mask
                             : 32'h0000_0000;

    // Events: busoff gated by its own mask, sticky status for software
    wire logic [31:0] evt_set = (32'(busoff_event & busoff_irq_enable) << CBT_IRQ_BOFF_POS)
                              | (32'(error_event & error_irq_enable) << CBT_IRQ_ERR_POS)
                              | (32'(next_mode == CBT_DISABLED && mode != CBT_DISABLED)
                                 << CBT_IRQ_LPACK_POS);
    wire logic [31:0] evt_clr = wr_stat ? strb_merge(32'h0000_0000, s_axi_wdata_q(),
                                                     w_strb, CBT_IRQ_WMASK) : 32'h0000_0000;

    function automatic logic [31:0] s_axi_wdata_q();
        return w_data;
    endfunction

    // disabled mode entered only once bus activity has ended
    // disable request drives the mode machine
    always_comb begin
        next_mode = mode;
        unique case (mode)
            CBT_RUN:      if (module_disable) next_mode = CBT_DRAINING;
            CBT_DRAINING: begin
                if (!module_disable) next_mode = CBT_RUN;
                else if (!bus_activity) next_mode = CBT_DISABLED;
            end
            CBT_DISABLED: if (!module_disable) next_mode = CBT_RUN;
        endcase
    end

    // divide the selected source by prescaler plus one
    // source select between oscillator enable and bus clock
    wire logic src_tick  = prescaler_source_sel ? 1'b1 : osc_clk_en;
    // Quantum keeps running while a frame drains; disabled mode or a freeze stops it
    wire logic presc_run = (mode != CBT_DISABLED) & ~freeze_req;
    // value zero wraps every source tick
    wire logic presc_wrap = src_tick & (presc_cnt == quantum_prescaler);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_cnt    <= 8'h00;
            quantum_tick <= 1'b0;
        end else begin
            // one tick per quantum for all segment timing
            quantum_tick <= presc_run & presc_wrap;
            if (!presc_run || presc_wrap) presc_cnt <= 8'h00;
            else if (src_tick) presc_cnt <= presc_cnt + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode          <= CBT_RUN;
            low_power_ack <= 1'b0;
        end else begin
            mode          <= next_mode;
            // flag follows disabled mode only, never written
            // drops as soon as disabled mode is left
            low_power_ack <= (next_mode == CBT_DISABLED);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            module_configuration <= CBT_MCR_RESET;
            can_bus_control      <= CBT_CTRL_RESET;
            irq_mask             <= CBT_IRQ_MASK_RESET;
            irq_status           <= 32'h0000_0000;
        end else begin
            if (wr_mcr) module_configuration <= strb_merge(module_configuration, w_data,
                                                           w_strb, CBT_MCR_WMASK);
            if (wr_ctrl) can_bus_control <= strb_merge(can_bus_control, w_data,
                                                       w_strb, ctrl_wmask);
            if (wr_mask) irq_mask <= strb_merge(irq_mask, w_data, w_strb, CBT_IRQ_WMASK);
            // Set wins over a same-cycle clear
            irq_status <= (irq_status & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 32'h0000_0000;
            aw_prot       <= 3'b000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= CBT_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                aw_prot <= s_axi_awprot;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_resp;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= CBT_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go & ~s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                // refused read returns zero with slave error
                s_axi_rdata  <= rd_priv_ok ? rd_mux : 32'h0000_0000;
                s_axi_rresp  <= ~rd_hit ? CBT_RESP_DECERR
                              : (rd_priv_ok ? CBT_RESP_OKAY : CBT_RESP_SLVERR);
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_buffer_count  <= 5'h10;
            resync_jump_width    <= 3'h1;
            phase_seg_one        <= 4'h1;
            phase_seg_two        <= 4'h1;
            sample_three         <= 1'b0;
            loop_back            <= 1'b0;
            busoff_recovery_ctrl <= 1'b0;
            can_clock_enable     <= 1'b1;
            freeze_active        <= 1'b0;
            busoff_irq           <= 1'b0;
            error_irq            <= 1'b0;
            irq                  <= 1'b0;
        end else begin
            // buffer count is index plus one
            active_buffer_count  <= {1'b0, last_buffer_index} + 5'h01;
            resync_jump_width    <= {1'b0, can_bus_control[CBT_JUMP_LSB +: 2]} + 3'h1;
            phase_seg_one        <= {1'b0, can_bus_control[CBT_PS1_LSB +: 3]} + 4'h1;
            phase_seg_two        <= {1'b0, can_bus_control[CBT_PS2_LSB +: 3]} + 4'h1;
            sample_three         <= can_bus_control[CBT_SMP_POS];
            loop_back            <= can_bus_control[CBT_LPB_POS];
            busoff_recovery_ctrl <= can_bus_control[CBT_RECOVER_POS];
            can_clock_enable     <= (next_mode != CBT_DISABLED);
            freeze_active        <= freeze_req;
            // bus-off request only when its mask is set
            busoff_irq           <= irq_status[CBT_IRQ_BOFF_POS] & busoff_irq_enable;
            error_irq            <= irq_status[CBT_IRQ_ERR_POS] & error_irq_enable;
            irq                  <= |(irq_status & irq_mask);
        end
    end
endmodule

// file: design/cbt_pkg.sv
// Register map, field layout and reset values for the CAN configuration and bit-timing block
package cbt_pkg;
    localparam logic [31:0] CBT_MCR_ADDR        = 32'h0017_0000;
    localparam logic [31:0] CBT_CTRL_ADDR       = 32'h0017_0004;
    localparam logic [31:0] CBT_IRQ_STATUS_ADDR = 32'h0017_0008;
    localparam logic [31:0] CBT_IRQ_MASK_ADDR   = 32'h0017_000C;
    localparam logic [31:0] CBT_ADDR_MASK       = 32'h00FF_FFFC;

    localparam int CBT_MOD_DIS_POS   = 31;
    localparam int CBT_FRZ_POS       = 30;
    localparam int CBT_HALT_POS      = 28;
    localparam int CBT_NOTRDY_POS    = 27;
    localparam int CBT_FRZACK_POS    = 24;
    localparam int CBT_PRIV_POS      = 23;
    localparam int CBT_LPACK_POS     = 20;
    localparam int CBT_LASTMB_LSB    = 0;
    localparam int CBT_PRESC_LSB     = 24;
    localparam int CBT_JUMP_LSB      = 22;
    localparam int CBT_PS1_LSB       = 19;
    localparam int CBT_PS2_LSB       = 16;
    localparam int CBT_BOFF_EN_POS   = 15;
    localparam int CBT_ERR_EN_POS    = 14;
    localparam int CBT_CLKSRC_POS    = 13;
    localparam int CBT_LPB_POS       = 12;
    localparam int CBT_SMP_POS       = 7;
    localparam int CBT_RECOVER_POS   = 6;
    localparam int CBT_IRQ_LPACK_POS = 0;
    localparam int CBT_IRQ_BOFF_POS  = 1;
    localparam int CBT_IRQ_ERR_POS   = 2;

    // Writable bit masks for each register
    localparam logic [31:0] CBT_MCR_WMASK       = 32'hD080_000F;
    localparam logic [31:0] CBT_CTRL_WMASK      = 32'hFFFF_F0C7;
    localparam logic [31:0] CBT_CTRL_ANYTIME    = 32'h0000_C040;
    localparam logic [31:0] CBT_IRQ_WMASK       = 32'h0000_0007;

    localparam logic [31:0] CBT_MCR_RESET       = 32'hD000_000F;
    localparam logic [31:0] CBT_CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] CBT_IRQ_MASK_RESET  = 32'h0000_0000;

    localparam logic [1:0] CBT_RESP_OKAY   = 2'b00;
    localparam logic [1:0] CBT_RESP_SLVERR = 2'b10;
    localparam logic [1:0] CBT_RESP_DECERR = 2'b11;

    typedef enum logic [2:0] {
        CBT_RUN      = 3'b001,
        CBT_DRAINING = 3'b010,
        CBT_DISABLED = 3'b100
    } cbt_mode_t;
endpackage

// file: sim/cbt_can_node.sv
// Far-side model: oscillator ticks, frame activity and fault events
`timescale 1ns/1ps
module cbt_can_node #(
    parameter int OSC_DIV   = 3,
    parameter int FRAME_LEN = 30
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic frame_start,
    input  wire logic busoff_req,
    input  wire logic error_req,
    output logic      osc_clk_en,
    output logic      bus_activity,
    output logic      busoff_event,
    output logic      error_event
);
    int osc_cnt;
    int frame_cnt;
    // Oscillator runs free, frames last a fixed length so disable must wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_cnt <= 0;
            frame_cnt <= 0;
            osc_clk_en <= 1'b0;
            bus_activity <= 1'b0;
            busoff_event <= 1'b0;
            error_event <= 1'b0;
        end else begin
            osc_cnt <= (osc_cnt == OSC_DIV - 1) ? 0 : osc_cnt + 1;
            osc_clk_en <= (osc_cnt == OSC_DIV - 1);
            frame_cnt <= frame_start ? FRAME_LEN : ((frame_cnt > 0) ? frame_cnt - 1 : 0);
            bus_activity <= frame_start || (frame_cnt > 1);
            busoff_event <= busoff_req;
            error_event <= error_req;
        end
    end
endmodule

// file: sim/cbt_core_properties.sv
// Port-level assertions for the configuration and bit-timing core
`timescale 1ns/1ps
module cbt_core_properties
    import cbt_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        bus_activity,
    input wire logic        quantum_tick,
    input wire logic        can_clock_enable,
    input wire logic        freeze_active,
    input wire logic        busoff_irq,
    input wire logic [4:0]  active_buffer_count,
    input wire logic [2:0]  resync_jump_width,
    input wire logic [3:0]  phase_seg_one,
    input wire logic [3:0]  phase_seg_two
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before ready");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response changed before ready");
    AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late after address taken");
    AST_SLVERR_ZERO: assert property (
        s_axi_rvalid && s_axi_rresp == CBT_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("refused read returned data");
    AST_DISABLE_WAITS: assert property ($fell(can_clock_enable) |-> !$past(bus_activity))
        else $error("disabled during bus activity");
    AST_NO_TICK_DISABLED: assert property (!can_clock_enable [*2] |-> !quantum_tick)
        else $error("quantum tick while disabled");
    AST_NO_TICK_FROZEN: assert property (freeze_active [*2] |-> !quantum_tick)
        else $error("quantum tick while frozen");
    AST_BUSOFF_STICKY: assert property (busoff_irq && !s_axi_bvalid |=> busoff_irq)
        else $error("bus-off request cleared without a write");
    AST_FIELD_RANGE: assert property (resync_jump_width inside {[1:4]} &&
        phase_seg_one inside {[1:8]} && phase_seg_two inside {[1:8]} &&
        active_buffer_count inside {[1:16]})
        else $error("timing or buffer count out of range");

    cover property (s_axi_rvalid && s_axi_rresp == CBT_RESP_SLVERR);
    cover property ($fell(can_clock_enable) ##1 can_clock_enable [*2]);
    cover property ($rose(busoff_irq));
endmodule

bind cbt_core cbt_core_properties i_props (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .bus_activity, .quantum_tick,
    .can_clock_enable, .freeze_active, .busoff_irq, .active_buffer_count,
    .resync_jump_width, .phase_seg_one, .phase_seg_two);

// file: sim/test_can_config_bit_timing.sv
// Self-checking bench for the configuration and bit-timing core
`timescale 1ns/1ps
`define CMP(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module test_can_config_bit_timing;
    import cbt_pkg::*;
    logic        aclk;
    logic        aresetn;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [2:0]  s_axi_awprot, s_axi_arprot, resync_jump_width;
    logic [3:0]  s_axi_wstrb, phase_seg_one, phase_seg_two;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [4:0]  active_buffer_count;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        osc_clk_en, bus_activity, busoff_event, error_event, debug_breakpoint;
    logic        quantum_tick, sample_three, loop_back, busoff_recovery_ctrl, can_clock_enable;
    logic        freeze_active, busoff_irq, error_irq, irq, frame_start, busoff_req, error_req;
    int          fails, checked, cyc;
    logic [31:0] cfg [3] = '{32'h0001_2000, 32'hFFFF_2000, 32'h019B_1080};
    int          per_exp [3] = '{1, 256, 6};
    logic [10:0] fld_exp [3] = '{{3'd1, 4'd1, 4'd2}, {3'd4, 4'd8, 4'd8}, {3'd3, 4'd4, 4'd4}};

    cbt_core i_cbt_core (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_clk_en,
        .debug_breakpoint, .bus_activity, .busoff_event, .error_event, .quantum_tick,
        .active_buffer_count, .resync_jump_width, .phase_seg_one, .phase_seg_two,
        .sample_three, .loop_back, .busoff_recovery_ctrl, .can_clock_enable, .freeze_active,
        .busoff_irq, .error_irq, .irq);
    cbt_can_node i_cbt_can_node (
        .aclk, .aresetn, .frame_start, .busoff_req, .error_req, .osc_clk_en, .bus_activity,
        .busoff_event, .error_event);

    always #12.5 aclk = ~aclk;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            final_report();
        end
    end

    task automatic wr(input logic [31:0] a, d, input logic p = 1'b1, input logic [1:0] er = 2'b00);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awprot <= {2'b00, p};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CMP(s_axi_bresp, er)
    endtask

    task automatic rd(input logic [31:0] a, m, e, input logic p = 1'b1,
                      input logic [1:0] er = 2'b00);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arprot <= {2'b00, p};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CMP(s_axi_rdata & m, e)
        `CMP(s_axi_rresp, er)
    endtask

    // Registered outputs need a few edges after the response
    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask

    task automatic per(input int e);
        int n;
        n = 0;
        while (quantum_tick !== 1'b1) @(posedge aclk);
        do begin
            @(posedge aclk);
            n++;
        end while (quantum_tick !== 1'b1);
        `CMP(n, e)
    endtask

    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, debug_breakpoint, frame_start, busoff_req, error_req} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wstrb = 4'hF;
        {fails, checked, cyc} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        `CMP(active_buffer_count, 5'd16)
        rd(CBT_MCR_ADDR, 32'h8010_000F, 32'h8010_000F);
        `CMP(can_clock_enable, 1'b0)
        rd(CBT_IRQ_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001);
        wr(CBT_IRQ_MASK_ADDR, 32'h0000_0001);
        settle();
        `CMP(irq, 1'b1)
        wr(CBT_IRQ_STATUS_ADDR, 32'h0000_0001);
        settle();
        `CMP(irq, 1'b0)
        wr(CBT_IRQ_MASK_ADDR, 32'h0000_0000);
        // Timing fields are only programmed while disabled
        for (int i = 0; i < 3; i++) begin
            wr(CBT_MCR_ADDR, 32'h8000_000F);
            wr(CBT_CTRL_ADDR, cfg[i]);
            rd(CBT_CTRL_ADDR, 32'hFFFF_F0C7, cfg[i]);
            `CMP({resync_jump_width, phase_seg_one, phase_seg_two}, fld_exp[i])
            wr(CBT_MCR_ADDR, 32'h0000_000F);
            settle();
            rd(CBT_MCR_ADDR, 32'h0010_0000, 32'h0000_0000);
            `CMP(can_clock_enable, 1'b1)
            per(per_exp[i]);
        end
        wr(CBT_CTRL_ADDR, 32'hFFFF_FFFF);
        `CMP({sample_three, loop_back}, 2'b11)
        rd(CBT_CTRL_ADDR, 32'hFFFF_F0C7, 32'h019B_D0C0);
        `CMP(busoff_recovery_ctrl, 1'b1)
        @(posedge aclk);
        {busoff_req, error_req} <= 2'b11;
        @(posedge aclk);
        {busoff_req, error_req} <= 2'b00;
        settle();
        `CMP({busoff_irq, error_irq, irq}, 3'b110)
        wr(CBT_IRQ_MASK_ADDR, 32'h0000_0002);
        settle();
        `CMP(irq, 1'b1)
        wr(CBT_IRQ_STATUS_ADDR, 32'h0000_0006);
        settle();
        `CMP({busoff_irq, error_irq, irq}, 3'b000)
        wr(CBT_CTRL_ADDR, 32'h019B_0000);
        @(posedge aclk);
        busoff_req <= 1'b1;
        @(posedge aclk);
        busoff_req <= 1'b0;
        settle();
        `CMP(busoff_irq, 1'b0)
        rd(CBT_IRQ_STATUS_ADDR, 32'h0000_0002, 32'h0000_0000);
        wr(CBT_MCR_ADDR, 32'h5000_000F);
        wr(CBT_MCR_ADDR, 32'h5010_0003);
        settle();
        `CMP(active_buffer_count, 5'd4)
        rd(CBT_MCR_ADDR, 32'h0010_000F, 32'h0000_0003);
        wr(CBT_MCR_ADDR, 32'h5000_0003);
        settle();
        `CMP(freeze_active, 1'b1)
        wr(CBT_MCR_ADDR, 32'h4000_0003);
        settle();
        `CMP(freeze_active, 1'b0)
        debug_breakpoint <= 1'b1;
        settle();
        `CMP(freeze_active, 1'b1)
        debug_breakpoint <= 1'b0;
        wr(CBT_MCR_ADDR, 32'h0080_0003);
        rd(CBT_MCR_ADDR, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0, CBT_RESP_SLVERR);
        wr(CBT_MCR_ADDR, 32'h0000_0003, 1'b0, CBT_RESP_SLVERR);
        rd(CBT_MCR_ADDR, 32'h0080_0000, 32'h0080_0000);
        wr(CBT_MCR_ADDR, 32'h0000_0003);
        rd(32'h0017_0010, 32'h0000_0000, 32'h0000_0000, 1'b1, CBT_RESP_DECERR);
        wr(32'h0017_0010, 32'h0000_0000, 1'b1, CBT_RESP_DECERR);
        wr(CBT_IRQ_STATUS_ADDR, 32'h0000_0001);
        @(posedge aclk);
        frame_start <= 1'b1;
        @(posedge aclk);
        frame_start <= 1'b0;
        wr(CBT_MCR_ADDR, 32'h8000_0003);
        rd(CBT_MCR_ADDR, 32'h0010_0000, 32'h0000_0000);
        `CMP(can_clock_enable, 1'b1)
        while (bus_activity) @(posedge aclk);
        settle();
        rd(CBT_MCR_ADDR, 32'h0010_0000, 32'h0010_0000);
        `CMP(can_clock_enable, 1'b0)
        rd(CBT_IRQ_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001);
        final_report();
    end
endmodule
